//--- src/mwts_pkg.sv
// mwts_pkg: register map, field layout and reset values of the microstep wave sequencer.
// assumes a plain strobe register port with 32-bit data and word indices as addresses.
package mwts_pkg;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [3:0] MWTS_IDX_WAVE0     = 4'h0;
  localparam logic [3:0] MWTS_IDX_WAVE7     = 4'h7;
  localparam logic [3:0] MWTS_IDX_SEGSEL    = 4'h8;
  localparam logic [3:0] MWTS_IDX_START     = 4'h9;
  localparam logic [3:0] MWTS_IDX_CTRL      = 4'hA;
  localparam logic [3:0] MWTS_IDX_STATUS    = 4'hB;
  localparam logic [3:0] MWTS_IDX_CURRENT   = 4'hC;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] MWTS_RST_WAVE0    = 32'hAAAA_B554;
  localparam logic [31:0] MWTS_RST_WAVE1    = 32'h4A95_54AA;
  localparam logic [31:0] MWTS_RST_WAVE2    = 32'h2449_2929;
  localparam logic [31:0] MWTS_RST_WAVE3    = 32'h1010_4222;
  localparam logic [31:0] MWTS_RST_WAVE4    = 32'h0FBF_FFFF;
  localparam logic [31:0] MWTS_RST_WAVE5    = 32'h4929_5556;
  localparam logic [31:0] MWTS_RST_WAVE6    = 32'h0000_0000;
  localparam logic [31:0] MWTS_RST_WAVE7    = 32'h0040_4222;
  localparam logic [31:0] MWTS_RST_SEGSEL   = 32'hFFFF_8056;
  localparam logic [31:0] MWTS_RST_START    = 32'h00F7_0000;
  localparam logic [31:0] MWTS_RST_CTRL     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MWTS_SEL_B1_LSB   = 8;   // first_segment_bound
  localparam int MWTS_SEL_B2_LSB   = 16;  // second_segment_bound
  localparam int MWTS_SEL_B3_LSB   = 24;  // third_segment_bound
  localparam int MWTS_START_A_LSB  = 0;   // coil_a_start_value
  localparam int MWTS_START_B_LSB  = 16;  // coil_b_start_value
  localparam int MWTS_START_OFS_LSB = 24; // coil_b_phase_offset
  localparam int MWTS_CTRL_STEP    = 0;   // write 1: advance one microstep
  localparam int MWTS_CTRL_DIR     = 1;   // direction of advance, 1 = down
  localparam logic [9:0] MWTS_QUARTER = 10'h100;
  localparam logic [7:0] MWTS_OFS_MIN = 8'h81; // -127

endpackage : mwts_pkg

//--- src/mwts_quarter_lookup.sv
// mwts_quarter_lookup: incremental quarter-wave decoder for one table index.
// assumes the table words and segment selector are stable while it is read.
module mwts_quarter_lookup
  import mwts_pkg::*;
#(
  parameter int WAVE_WORDS = 8
) (
  input  wire logic [WAVE_WORDS*32-1:0] wave_bits_i,
  input  wire logic [31:0]              seg_sel_i,
  input  wire logic [7:0]               index_i,
  output logic signed [9:0]             step_o
);

  if (WAVE_WORDS != 8) begin : g_bad_words
    $error("quarter table needs exactly eight words");
  end

  // ---------------------------------------------------------------
  // slope decode
  // ---------------------------------------------------------------
  // two-bit code 0..3 maps to -1, 0, 1, 2
  function automatic logic signed [9:0] mwts_slope(input logic [1:0] code);
    mwts_slope = $signed({8'h00, code}) - 10'sd1;
  endfunction : mwts_slope

  logic [7:0] bound1;
  logic [7:0] bound2;
  logic [7:0] bound3;
  logic [1:0] code;

  assign bound1 = seg_sel_i[MWTS_SEL_B1_LSB +: 8];
  assign bound2 = seg_sel_i[MWTS_SEL_B2_LSB +: 8];
  assign bound3 = seg_sel_i[MWTS_SEL_B3_LSB +: 8];

  always_comb begin
    code = seg_sel_i[1:0];
    if (index_i >= bound3) begin
      code = seg_sel_i[7:6];
    end else if (index_i >= bound2) begin
      code = seg_sel_i[5:4];
    end else if (index_i >= bound1) begin
      code = seg_sel_i[3:2];
    end
  end

  // entry bit adds one on top of the base slope
  assign step_o = mwts_slope(code) + $signed({9'h000, wave_bits_i[index_i]});

endmodule : mwts_quarter_lookup

//--- src/mwts_sequencer.sv
// mwts_sequencer: microstep wave table, register file and two-coil current sequencer.
// assumes a single-clock register port; step requests come from software or step_i.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
module mwts_sequencer
  import mwts_pkg::*;
#(
  parameter int WAVE_WORDS = 8
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic        step_i,
  input  wire logic        dir_i,
  output logic [9:0]       microstep_position_counter_o,
  output logic [8:0]       coil_a_current_o,
  output logic [8:0]       coil_b_current_o
);

  if (WAVE_WORDS != 8) begin : g_bad_words
    $error("quarter table needs exactly eight words");
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0]       wave_bits_word [WAVE_WORDS];
  logic [31:0]       wave_segment_select;
  logic [31:0]       wave_start_values;
  logic              dir_sw;
  logic [9:0]        microstep_position_counter;
  logic signed [8:0] coil_a_current;
  logic signed [8:0] coil_b_current;
  logic [9:0]        pos_b;
  logic signed [9:0] quarter_a;
  logic signed [9:0] quarter_b;
  logic [WAVE_WORDS*32-1:0] wave_flat;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // quarter table index for a full-turn position; odd quarters read backwards
  // callers pass the lower of the two positions crossed by the step
  function automatic logic [7:0] mwts_index(input logic [9:0] pos);
    mwts_index = pos[8] ? ~pos[7:0] : pos[7:0];
  endfunction : mwts_index

  // signed value in second half turn is the negative of the quarter value
  function automatic logic signed [8:0] mwts_apply(input logic signed [8:0] cur,
                                                     input logic signed [9:0] inc,
                                                     input logic [9:0] pos,
                                                     input logic down);
    logic rising;
    logic signed [9:0] sum;
    // rising magnitude in quarters 0 and 2 when moving up, the reverse when moving down
    rising = pos[8] ~^ down;
    sum = rising ? (10'(cur) + (pos[9] ? -inc : inc))
                 : (10'(cur) - (pos[9] ? -inc : inc));
    mwts_apply = sum[8:0];
  endfunction : mwts_apply

  // absolute value at a quarter boundary; only zero and peak points are known exactly
  function automatic logic signed [8:0] mwts_anchor(input logic [9:0] pos,
                                                      input logic [7:0] a0,
                                                      input logic [7:0] b0);
    logic signed [8:0] mag;
    mag = pos[8] ? $signed({1'b0, b0}) : $signed({1'b0, a0});
    mwts_anchor = pos[9] ? -mag : mag;
  endfunction : mwts_anchor

  always_comb begin
    for (int i = 0; i < WAVE_WORDS; i++) begin
      wave_flat[i*32 +: 32] = wave_bits_word[i];
    end
  end

  // ---------------------------------------------------------------
  // stepping
  // ---------------------------------------------------------------
  logic       sw_step;
  logic       do_step;
  logic       down;
  logic [9:0] next_pos;
  logic [9:0] next_pos_b;
  logic [7:0] start_a;
  logic [7:0] start_b;
  logic [9:0] ofs_b;

  assign sw_step = reg_write_i && (reg_addr_i == MWTS_IDX_CTRL) && reg_wdata_i[MWTS_CTRL_STEP];
  assign do_step = sw_step || step_i;
  assign down    = sw_step ? reg_wdata_i[MWTS_CTRL_DIR] : (dir_i | dir_sw);
  assign next_pos = down ? microstep_position_counter - 10'h001
                         : microstep_position_counter + 10'h001;
  assign start_a = wave_start_values[MWTS_START_A_LSB +: 8];
  assign start_b = wave_start_values[MWTS_START_B_LSB +: 8];
  // offset range is -127..+127, so the code -128 is pinned to -127
  assign ofs_b = (wave_start_values[MWTS_START_OFS_LSB +: 8] == 8'h80)
               ? {2'b11, MWTS_OFS_MIN}
               : {{2{wave_start_values[31]}}, wave_start_values[MWTS_START_OFS_LSB +: 8]};
  // coil B leads by 256 microsteps plus the signed offset
  assign pos_b = microstep_position_counter + MWTS_QUARTER + ofs_b;
  assign next_pos_b = next_pos + MWTS_QUARTER + ofs_b;

  mwts_quarter_lookup #(
    .WAVE_WORDS (WAVE_WORDS)
  ) u_lookup_a (
    .wave_bits_i (wave_flat),
    .seg_sel_i   (wave_segment_select),
    .index_i     (mwts_index(down ? next_pos : microstep_position_counter)),
    .step_o      (quarter_a)
  );

  mwts_quarter_lookup #(
    .WAVE_WORDS (WAVE_WORDS)
  ) u_lookup_b (
    .wave_bits_i (wave_flat),
    .seg_sel_i   (wave_segment_select),
    .index_i     (mwts_index(down ? next_pos_b : pos_b)),
    .step_o      (quarter_b)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      microstep_position_counter <= 10'h000;
    end else if (do_step) begin
      microstep_position_counter <= next_pos;
    end
  end

  // the lookup uses the index being crossed: the entry left behind going up,
  // the entry entered going down, so both directions retrace the same values
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      coil_a_current <= 9'sh000;
    end else if (do_step) begin
      if (next_pos == 10'h000) begin
        coil_a_current <= $signed({1'b0, start_a});
      end else if (next_pos[7:0] == 8'h00) begin
        coil_a_current <= mwts_anchor(next_pos, start_a, start_b);
      end else begin
        coil_a_current <= mwts_apply(coil_a_current, quarter_a, next_pos, down);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      coil_b_current <= 9'sh000;
    end else if (do_step) begin
      if (next_pos == 10'h000) begin
        coil_b_current <= mwts_anchor(next_pos_b, start_a, start_b);
      end else if (next_pos_b[7:0] == 8'h00) begin
        coil_b_current <= mwts_anchor(next_pos_b, start_a, start_b);
      end else begin
        coil_b_current <= mwts_apply(coil_b_current, quarter_b, next_pos_b, down);
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wave_bits_word[0] <= MWTS_RST_WAVE0;
      wave_bits_word[1] <= MWTS_RST_WAVE1;
      wave_bits_word[2] <= MWTS_RST_WAVE2;
      wave_bits_word[3] <= MWTS_RST_WAVE3;
      wave_bits_word[4] <= MWTS_RST_WAVE4;
      wave_bits_word[5] <= MWTS_RST_WAVE5;
      wave_bits_word[6] <= MWTS_RST_WAVE6;
      wave_bits_word[7] <= MWTS_RST_WAVE7;
    end else if (reg_write_i && reg_addr_i <= MWTS_IDX_WAVE7) begin
      wave_bits_word[reg_addr_i[2:0]] <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wave_segment_select <= MWTS_RST_SEGSEL;
      wave_start_values   <= MWTS_RST_START;
      dir_sw              <= MWTS_RST_CTRL[MWTS_CTRL_DIR];
    end else if (reg_write_i) begin
      case (reg_addr_i)
        MWTS_IDX_SEGSEL: wave_segment_select <= reg_wdata_i;
        MWTS_IDX_START:  wave_start_values   <= reg_wdata_i;
        MWTS_IDX_CTRL:   dir_sw              <= reg_wdata_i[MWTS_CTRL_DIR];
        default:         dir_sw              <= dir_sw;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        MWTS_IDX_SEGSEL:  reg_rdata_o <= wave_segment_select;
        MWTS_IDX_START:   reg_rdata_o <= wave_start_values;
        MWTS_IDX_CTRL:    reg_rdata_o <= {30'h0000_0000, dir_sw, 1'b0};
        MWTS_IDX_STATUS:  reg_rdata_o <= {22'h00_0000, microstep_position_counter};
        MWTS_IDX_CURRENT: reg_rdata_o <= {7'h00, coil_b_current, 7'h00, coil_a_current};
        default: begin
          if (reg_addr_i <= MWTS_IDX_WAVE7) begin
            reg_rdata_o <= wave_bits_word[reg_addr_i[2:0]];
          end else begin
            reg_rdata_o <= 32'h0000_0000;
          end
        end
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      microstep_position_counter_o <= 10'h000;
      coil_a_current_o             <= 9'h000;
      coil_b_current_o             <= 9'h000;
    end else begin
      microstep_position_counter_o <= microstep_position_counter;
      coil_a_current_o             <= coil_a_current;
      coil_b_current_o             <= coil_b_current;
    end
  end

endmodule : mwts_sequencer

//--- tb/mwts_props.sv
// mwts_props: port-level checks of the microstep wave sequencer.
// assumes it is bound to mwts_sequencer and coil A start is left at 0.
module mwts_props
  import mwts_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        step_i,
  input wire logic        dir_i,
  input wire logic [9:0]  microstep_position_counter_o,
  input wire logic [8:0]  coil_a_current_o,
  input wire logic [8:0]  coil_b_current_o
);
  // ---------------------------------------------------------------
  // shadow registers and checks
  // ---------------------------------------------------------------
  logic [31:0]      start;
  logic [31:0]      segsel;
  wire logic [9:0]  pos = microstep_position_counter_o;
  wire logic        wr_start = reg_write_i && reg_addr_i == MWTS_IDX_START;
  wire logic        wr_sel = reg_write_i && reg_addr_i == MWTS_IDX_SEGSEL;
  always_ff @(posedge ref_clk_i) start <= rst_i ? MWTS_RST_START : wr_start ? reg_wdata_i : start;
  always_ff @(posedge ref_clk_i) segsel <= rst_i ? MWTS_RST_SEGSEL : wr_sel ? reg_wdata_i : segsel;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_RDATA_IDLE: assert property (
    !$past(reg_read_i) |-> reg_rdata_o == 32'h0000_0000) else $error("read data not idle");
  AST_HOLD: assert property (
    !$past(step_i, 2) && !$past(reg_write_i, 2) |-> $stable(pos) && $stable(coil_a_current_o))
    else $error("outputs moved without a step");
  // the counter output lags the step by two edges, consecutive steps included
  AST_STEP_UP: assert property (
    step_i && !dir_i && !reg_write_i |-> ##2 pos == $past(pos) + 10'h001)
    else $error("counter did not count up");
  AST_STEP_DOWN: assert property (
    step_i && dir_i && !reg_write_i |-> ##2 pos == $past(pos) - 10'h001)
    else $error("counter did not count down");
  AST_ZERO_RELOAD: assert property (
    $changed(pos) && pos == 10'h000 && start[31:24] == 8'h00
    |-> coil_a_current_o == {1'b0, start[7:0]} && coil_b_current_o == {1'b0, start[23:16]})
    else $error("currents not reloaded at zero");
  AST_QUARTER_PEAK: assert property (
    $changed(pos) && pos == 10'h100 && start[31:24] == 8'h00
    |-> coil_a_current_o == {1'b0, start[23:16]}) else $error("coil A peak wrong");
  AST_HALF_NEG: assert property (
    $changed(pos) && pos == 10'h200 && start[31:24] == 8'h00
    |-> coil_b_current_o == 9'h000 - {1'b0, start[23:16]}) else $error("coil B not negated");
  AST_START_READ: assert property (
    reg_read_i && reg_addr_i == MWTS_IDX_START |=> reg_rdata_o == start)
    else $error("start word readback wrong");
  AST_SEGSEL_READ: assert property (
    reg_read_i && reg_addr_i == MWTS_IDX_SEGSEL |=> reg_rdata_o == segsel)
    else $error("segment selector readback wrong");
endmodule : mwts_props

bind mwts_sequencer mwts_props u_props (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_read_i, .reg_rdata_o, .step_i, .dir_i, .microstep_position_counter_o,
  .coil_a_current_o, .coil_b_current_o);

//--- tb/mwts_coil_stage.sv
// mwts_coil_stage: behavioural stand-in for the coil current regulation stage.
// assumes signed 9-bit coil currents, taken on every clock edge.
module mwts_coil_stage (
  input  wire logic        clk_i,
  input  wire logic        clear_i,
  input  wire logic [8:0]  coil_a_i,
  input  wire logic [8:0]  coil_b_i,
  output logic      [8:0]  peak_o,
  output logic      [23:0] per_phase_load_reading_a_o,
  output logic      [23:0] per_phase_load_reading_b_o
);
  // ---------------------------------------------------------------
  // peak tracking
  // ---------------------------------------------------------------
  // a peak above 248 would leave no headroom for the chopper offset
  function automatic logic [8:0] mwts_mag(input logic [8:0] v);
    return v[8] ? 9'h000 - v : v;
  endfunction : mwts_mag
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      peak_o <= 9'h000;
    end else if (mwts_mag(coil_a_i) > peak_o || mwts_mag(coil_b_i) > peak_o) begin
      peak_o <= mwts_mag(coil_a_i) > mwts_mag(coil_b_i) ? mwts_mag(coil_a_i) : mwts_mag(coil_b_i);
    end
  end
  // summed current magnitude per coil stands in for the per-phase load reading
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      per_phase_load_reading_a_o <= 24'h00_0000;
      per_phase_load_reading_b_o <= 24'h00_0000;
    end else begin
      per_phase_load_reading_a_o <= per_phase_load_reading_a_o + 24'(mwts_mag(coil_a_i));
      per_phase_load_reading_b_o <= per_phase_load_reading_b_o + 24'(mwts_mag(coil_b_i));
    end
  end
endmodule : mwts_coil_stage

//--- tb/tb_top.sv
// tb_top: register and step driven checks of the microstep wave sequencer.
// assumes the checker is bound in and the coil stage model sits on the outputs.
module tb_top
  import mwts_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // bench signals and tasks
  // ---------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, step = 1'b0, dir = 1'b0, clr = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, v, w;
  logic [9:0]  pos;
  logic [8:0]  ca, cb, peak;
  logic [23:0] load_a, load_b;
  logic [8:0]  wa [1024];
  logic [8:0]  wb [1024];
  int          failures = 0, cmp_count = 0, cyc = 0;
  logic [31:0] rv [10] = '{MWTS_RST_WAVE0, MWTS_RST_WAVE1, MWTS_RST_WAVE2, MWTS_RST_WAVE3,
    MWTS_RST_WAVE4, MWTS_RST_WAVE5, MWTS_RST_WAVE6, MWTS_RST_WAVE7, MWTS_RST_SEGSEL, MWTS_RST_START};

  always #50 clk = ~clk;
  mwts_sequencer dut (.ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .step_i(step), .dir_i(dir),
    .microstep_position_counter_o(pos), .coil_a_current_o(ca), .coil_b_current_o(cb));
  mwts_coil_stage u_coil (.clk_i(clk), .clear_i(rst | clr), .coil_a_i(ca), .coil_b_i(cb),
    .peak_o(peak), .per_phase_load_reading_a_o(load_a), .per_phase_load_reading_b_o(load_b));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // step held n edges gives n back-to-back steps; outputs settle two edges later
  task automatic steps(input int n, input logic d);
    @(posedge clk);
    step <= 1'b1;
    dir <= d;
    repeat (n) @(posedge clk);
    step <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : steps
  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    do_reset();
    for (int i = 0; i < 10; i++) begin
      rd_reg(4'(i), v);
      check(v, rv[i]);
    end
    wr_reg(4'hE, 32'hFFFF_FFFF);
    rd_reg(4'hE, v);
    check(v, 32'h0000_0000);
    wr_reg(MWTS_IDX_WAVE7, 32'h1234_5678);
    rd_reg(MWTS_IDX_WAVE7, v);
    check(v, 32'h1234_5678);
    wr_reg(MWTS_IDX_START, 32'h81F7_0000);
    rd_reg(MWTS_IDX_START, v);
    check(v, 32'h81F7_0000);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr_reg(MWTS_IDX_SEGSEL, {24'hFF_FFFF, 6'b01_0101, 2'(c)});
      wr_reg(MWTS_IDX_WAVE0, 32'h0000_0003);
      steps(10, 1'b0);
      check({23'h0, ca}, {23'h0, 9'(10 * c - 8)});
    end
    $display("test slope codes done");
    do_reset();
    wr_reg(MWTS_IDX_WAVE0, 32'h0000_0000);
    wr_reg(MWTS_IDX_SEGSEL, 32'hFFFF_0559);
    steps(10, 1'b0);
    check({23'h0, ca}, 32'h0000_0005);
    wr_reg(MWTS_IDX_CTRL, 32'h0000_0003);
    rd_reg(MWTS_IDX_CTRL, v);
    check(v, 32'h0000_0002);
    wr_reg(MWTS_IDX_CTRL, 32'h0000_0000);
    #1;
    check({22'h0, pos}, 32'h0000_0009);
    check({23'h0, ca}, 32'h0000_0004);
    $display("test segments done");
    do_reset();
    steps(1, 1'b1);
    check({22'h0, pos}, 32'h0000_03FF);
    rd_reg(MWTS_IDX_STATUS, v);
    check(v, 32'h0000_03FF);
    steps(1, 1'b0);
    check({23'h0, cb}, 32'h0000_00F7);
    rd_reg(MWTS_IDX_CURRENT, v);
    check(v, 32'h00F7_0000);
    $display("test wrap done");
    do_reset();
    steps(1024, 1'b0);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    for (int p = 0; p < 1024; p++) begin
      steps(1, 1'b0);
      wa[pos] = ca;
      wb[pos] = cb;
    end
    for (int p = 0; p < 512; p++) begin
      check({23'h0, wa[p]}, {23'h0, 9'h000 - wa[p + 512]});
      check({23'h0, wb[p]}, {23'h0, wa[p + 256]});
      check({23'h0, wb[p + 512]}, {23'h0, wa[(p + 768) % 1024]});
    end
    check({23'h0, wa[256]}, 32'h0000_00F7);
    check({23'h0, peak}, 32'h0000_00F7);
    // trim the coil B offset one step toward equal load readings
    w = {(load_a > load_b) ? 8'h01 : 8'hFF, 8'hF7, 16'h0000};
    wr_reg(MWTS_IDX_START, w);
    rd_reg(MWTS_IDX_START, v);
    check(v, w);
    $display("test full turn done");
    do_reset();
    wr_reg(MWTS_IDX_START, 32'h05F7_0000);
    steps(507, 1'b0);
    check({23'h0, cb}, 32'h0000_0109);
    do_reset();
    wr_reg(MWTS_IDX_START, 32'h80F7_0000);
    steps(127, 1'b0);
    check({23'h0, cb}, 32'h0000_00F7);
    $display("test phase offset done");
    conclude();
  end
endmodule : tb_top
